// >>> logic/vhz_pkg.sv
/*
  Constants and types for the volts-per-hertz profile generator.
  Assumes a 25 MHz clock and an APB master on the same clock.
*/
package vhz_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL = 16'h8050;
  localparam logic [15:0] IDX_SPEED = 16'h8051;
  localparam logic [15:0] IDX_STATUS = 16'h8052;
  localparam logic [15:0] IDX_VOLT = 16'h8053;
  localparam logic [15:0] IDX_SLEW = 16'h8065;
  localparam logic [15:0] IDX_POLES = 16'h8070;
  localparam logic [15:0] IDX_RATEDV = 16'h8071;
  localparam logic [15:0] IDX_RATEDF = 16'h8072;
  localparam logic [15:0] IDX_MINF = 16'h80a0;
  localparam logic [15:0] IDX_MAXF = 16'h80a1;
  localparam logic [15:0] IDX_INFLF = 16'h80a2;
  localparam logic [15:0] IDX_BOOSTV = 16'h80a3;
  localparam logic [15:0] IDX_STARTF = 16'h80a5;
  localparam logic [15:0] IDX_PAUSE = 16'h80a6;
  localparam int ADDR_W = 18;
  // Control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_ACI = 1;
  // Reset values; frequency in 0.1 Hz, voltage in 0.1 V
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [15:0] RST_SPEED = 16'h0000;
  localparam logic [15:0] RST_SLEW = 16'h0001;
  localparam logic [15:0] RST_POLES = 16'h0002;
  localparam logic [15:0] RST_RATEDV = 16'h11f8;
  localparam logic [15:0] RST_RATEDF = 16'h0258;
  localparam logic [15:0] RST_MINF = 16'h0000;
  localparam logic [15:0] RST_MAXF = 16'h04b0;
  localparam logic [15:0] RST_INFLF = 16'h0000;
  localparam logic [15:0] RST_BOOSTV = 16'h0000;
  localparam logic [15:0] RST_STARTF = 16'h0000;
  localparam logic [15:0] RST_PAUSE = 16'h0000;
  // rpm * pole pairs / 6 gives 0.1 Hz units
  localparam logic [31:0] RPM_TO_DHZ_DIV = 32'h0000_0006;
  // Slew and pause time base
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_RUN} vhzState_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] volt;
    logic running;
  } vhzOut_t;
endpackage : vhz_pkg

// >>> logic/vhz_profile.sv
/*
  Volts-per-hertz profile generator with an APB register slave.
  Assumes an APB master on mclk and a modulator that samples motorOut.
*/
`timescale 1ns/100ps
// Overview of operation
// - Voltage follows frequency by a volts-per-hertz law, induction motors only.
// - Basic curve is a line from zero to rated voltage at rated frequency.
// - Speed command times pole pairs gives target frequency; voltage by rated ratio.
// - Applied frequency ramps toward target at the slew rate, jumping only at turn-on and turn-off.
// - Above rated frequency, up to maximum, voltage holds at rated voltage.
// - A boost voltage at zero frequency raises the low-speed curve.
// - Inflection frequency marks where boost curve meets the rated line.
// - Target frequencies below the minimum are replaced by the minimum.
// - At turn-on the drive starts at the starting frequency.
// - Starting frequency is held for the pause time, then slewing begins.
// - Operation is open loop; no motor feedback is used.
module vhz_profile #(
  parameter int TICK_CYCLES = vhz_pkg::TICK_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vhz_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output vhz_pkg::vhzOut_t motorOut
);
  import vhz_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic [1:0] ctrlQ;
  logic [15:0] speedQ, slewQ, polesQ, ratedVQ, ratedFQ;
  logic [15:0] minFQ, maxFQ, inflFQ, boostVQ, startFQ, pauseQ;
  logic readyQ, errQ;
  logic [31:0] rdataQ;
  logic [31:0] rdMux;
  vhzState_t stateQ;
  vhzOut_t outQ;

  wire [15:0] idx = paddr[ADDR_W-1:2];
  wire setup = psel & ~penable & ~readyQ;
  wire wrAcc = psel & penable & readyQ & pwrite & ~errQ;

  function automatic logic isMapped(input logic [15:0] i);
    unique case (i)
      IDX_CTRL, IDX_SPEED, IDX_STATUS, IDX_VOLT, IDX_SLEW, IDX_POLES,
      IDX_RATEDV, IDX_RATEDF, IDX_MINF, IDX_MAXF, IDX_INFLF,
      IDX_BOOSTV, IDX_STARTF, IDX_PAUSE: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  always_comb begin
    unique case (idx)
      IDX_CTRL: rdMux = {30'h0, ctrlQ};
      IDX_SPEED: rdMux = {16'h0, speedQ};
      IDX_STATUS: rdMux = {14'h0, stateQ, outQ.freq};
      IDX_VOLT: rdMux = {16'h0, outQ.volt};
      IDX_SLEW: rdMux = {16'h0, slewQ};
      IDX_POLES: rdMux = {16'h0, polesQ};
      IDX_RATEDV: rdMux = {16'h0, ratedVQ};
      IDX_RATEDF: rdMux = {16'h0, ratedFQ};
      IDX_MINF: rdMux = {16'h0, minFQ};
      IDX_MAXF: rdMux = {16'h0, maxFQ};
      IDX_INFLF: rdMux = {16'h0, inflFQ};
      IDX_BOOSTV: rdMux = {16'h0, boostVQ};
      IDX_STARTF: rdMux = {16'h0, startFQ};
      IDX_PAUSE: rdMux = {16'h0, pauseQ};
      default: rdMux = 32'h0;
    endcase
  end

  // One wait-free access cycle: answer presented in the access phase
  always_ff @(posedge mclk) begin
    if (reset) begin
      readyQ <= 1'b0;
      errQ <= 1'b0;
      rdataQ <= 32'h0;
    end else begin
      readyQ <= setup;
      errQ <= setup & ~isMapped(idx);
      rdataQ <= (setup & ~pwrite) ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlQ <= RST_CTRL;
      speedQ <= RST_SPEED;
      slewQ <= RST_SLEW;
      polesQ <= RST_POLES;
      ratedVQ <= RST_RATEDV;
      ratedFQ <= RST_RATEDF;
      minFQ <= RST_MINF;
      maxFQ <= RST_MAXF;
      inflFQ <= RST_INFLF;
      boostVQ <= RST_BOOSTV;
      startFQ <= RST_STARTF;
      pauseQ <= RST_PAUSE;
    end else if (wrAcc) begin
      case (idx)
        IDX_CTRL: ctrlQ <= pwdata[1:0];
        IDX_SPEED: speedQ <= pwdata[15:0];
        IDX_SLEW: slewQ <= pwdata[15:0];
        IDX_POLES: polesQ <= pwdata[15:0];
        IDX_RATEDV: ratedVQ <= pwdata[15:0];
        IDX_RATEDF: ratedFQ <= pwdata[15:0];
        IDX_MINF: minFQ <= pwdata[15:0];
        IDX_MAXF: maxFQ <= pwdata[15:0];
        IDX_INFLF: inflFQ <= pwdata[15:0];
        IDX_BOOSTV: boostVQ <= pwdata[15:0];
        IDX_STARTF: startFQ <= pwdata[15:0];
        IDX_PAUSE: pauseQ <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Target frequency
  // ****************************************
  // Open loop: only the command and settings feed the profile
  wire [31:0] rawProd = speedQ * polesQ;
  wire [31:0] rawF = rawProd / RPM_TO_DHZ_DIV;
  wire [15:0] satF = (rawF > 32'h0000_ffff) ? 16'hffff : rawF[15:0];
  wire [15:0] loF = (satF < minFQ) ? minFQ : satF;
  wire [15:0] tgtF = (loF > maxFQ) ? maxFQ : loF;

  // ****************************************
  // Sequencer and slew
  // ****************************************
  logic [15:0] freqQ, freqD;
  logic [15:0] pauseCntQ;
  logic [31:0] tickCntQ;
  vhzState_t stateD;
  wire go = ctrlQ[CTRL_ENABLE] & ctrlQ[CTRL_ACI];
  wire tick = (tickCntQ == 32'(TICK_CYCLES - 1));
  wire [16:0] pauseNext = {1'b0, pauseCntQ} + 17'h1;
  wire pauseDone = tick & (pauseNext >= {1'b0, pauseQ});
  wire [15:0] upGap = tgtF - freqQ;
  wire [15:0] dnGap = freqQ - tgtF;
  wire [15:0] upF = (upGap > slewQ) ? freqQ + slewQ : tgtF;
  wire [15:0] dnF = (dnGap > slewQ) ? freqQ - slewQ : tgtF;

  always_comb begin
    stateD = stateQ;
    freqD = freqQ;
    unique case (stateQ)
      ST_OFF: begin
        freqD = 16'h0;
        if (go) begin
          stateD = ST_HOLD;
          freqD = startFQ;
        end
      end
      ST_HOLD: begin
        if (!go) begin
          stateD = ST_OFF;
          freqD = 16'h0;
        end else if (pauseDone) begin
          stateD = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!go) begin
          stateD = ST_OFF;
          freqD = 16'h0;
        end else if (tick) begin
          freqD = (tgtF >= freqQ) ? upF : dnF;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stateQ <= ST_OFF;
      freqQ <= 16'h0;
      tickCntQ <= 32'h0;
      pauseCntQ <= 16'h0;
    end else begin
      stateQ <= stateD;
      freqQ <= freqD;
      tickCntQ <= (stateQ == ST_OFF || tick) ? 32'h0 : tickCntQ + 32'h1;
      pauseCntQ <= (stateQ != ST_HOLD) ? 16'h0 : (tick ? pauseNext[15:0] : pauseCntQ);
    end
  end

  // ****************************************
  // Voltage profile
  // ****************************************
  wire [31:0] lineProd = freqQ * ratedVQ;
  wire [31:0] inflProd = inflFQ * ratedVQ;
  wire [31:0] lineV = lineProd / {16'h0, ratedFQ};
  wire [31:0] inflV = inflProd / {16'h0, ratedFQ};
  wire signed [33:0] boostDiff = $signed({2'b00, inflV}) - $signed({18'h0, boostVQ});
  wire signed [50:0] boostProd = boostDiff * $signed({1'b0, freqQ});
  wire signed [50:0] boostQuo = boostProd / $signed({35'h0, inflFQ});
  wire [15:0] boostV = 16'(boostQuo + $signed({35'h0, boostVQ}));
  logic [15:0] voltD;

  always_comb begin
    if (ratedFQ == 16'h0) begin
      voltD = 16'h0;
    end else if (freqQ >= ratedFQ) begin
      voltD = ratedVQ;
    end else if (freqQ < inflFQ) begin
      voltD = boostV;
    end else begin
      voltD = lineV[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      outQ <= '0;
    end else if (stateQ == ST_OFF) begin
      outQ <= '0;
    end else begin
      outQ <= '{freq: freqQ, volt: voltD, running: 1'b1};
    end
  end

  assign prdata = rdataQ;
  assign pready = readyQ;
  assign pslverr = errQ;
  assign motorOut = outQ;

  // ****************************************
  // Checks
  // ****************************************
  sequence sqTurnOn;
    stateQ == ST_OFF ##1 stateQ == ST_HOLD;
  endsequence

  sequence sqHoldEnd;
    stateQ == ST_HOLD ##1 stateQ == ST_RUN;
  endsequence

  AST_OFF_ZERO: assert property (@(posedge mclk) disable iff (reset)
    !go |-> ##2 (outQ.freq == 16'h0 && outQ.volt == 16'h0))
    else $error("Output not zero while off");
  AST_LINE: assert property (@(posedge mclk) disable iff (reset)
    (stateQ != ST_OFF && freqQ >= inflFQ && freqQ < ratedFQ)
    |=> outQ.volt == $past(lineV[15:0]))
    else $error("Voltage off the rated line");
  AST_SLEW: assert property (@(posedge mclk) disable iff (reset)
    (stateQ == ST_RUN && stateD == ST_RUN) |=>
    ((freqQ >= $past(freqQ)) ? (freqQ - $past(freqQ) <= $past(slewQ))
                             : ($past(freqQ) - freqQ <= $past(slewQ))))
    else $error("Frequency step above slew rate");
  AST_RATED_CAP: assert property (@(posedge mclk) disable iff (reset)
    (stateQ != ST_OFF && ratedFQ != 16'h0 && freqQ >= ratedFQ)
    |=> outQ.volt == $past(ratedVQ))
    else $error("Voltage not held at rated above rated frequency");
  AST_BOOST: assert property (@(posedge mclk) disable iff (reset)
    (stateQ != ST_OFF && freqQ == 16'h0 && inflFQ != 16'h0 && ratedFQ != 16'h0)
    |=> outQ.volt == $past(boostVQ))
    else $error("Zero frequency voltage not the boost value");
  AST_MIN: assert property (@(posedge mclk) disable iff (reset)
    (minFQ <= maxFQ) |-> tgtF >= minFQ)
    else $error("Target below minimum frequency");
  AST_START: assert property (@(posedge mclk) disable iff (reset)
    sqTurnOn |-> freqQ == $past(startFQ))
    else $error("Turn-on not at starting frequency");
  AST_PAUSE: assert property (@(posedge mclk) disable iff (reset)
    sqHoldEnd |-> $past(pauseDone))
    else $error("Slewing began before pause ended");
  AST_HOLD_FIX: assert property (@(posedge mclk) disable iff (reset)
    (stateQ == ST_HOLD ##1 stateQ == ST_HOLD) |-> $stable(freqQ))
    else $error("Frequency moved during pause");
  AST_APB_ANSWER: assert property (@(posedge mclk) disable iff (reset)
    setup |=> readyQ ##1 !readyQ)
    else $error("APB answer not one cycle after setup");

  // Unmapped index: error flag, zero data
  AST_APB_ERR: assert property (@(posedge mclk) disable iff (reset)
    (setup && !isMapped(idx)) |=> (errQ && readyQ && rdataQ == 32'h0))
    else $error("Unmapped index not refused");

  // Profile only runs with an induction motor selected
  AST_ACI_ONLY: assert property (@(posedge mclk) disable iff (reset)
    !ctrlQ[CTRL_ACI] |=> stateQ == ST_OFF)
    else $error("Profile active without induction motor selected");
  AST_OFF_FLAG: assert property (@(posedge mclk) disable iff (reset)
    (stateQ == ST_OFF) |=> !outQ.running)
    else $error("Running flag set while off");

  // While running, frequency only moves on a slew tick
  AST_RUN_STILL: assert property (@(posedge mclk) disable iff (reset)
    (stateQ == ST_RUN && go && !tick) |=> freqQ == $past(freqQ))
    else $error("Frequency moved between ticks");
  AST_MAX_CAP: assert property (@(posedge mclk) disable iff (reset)
    tgtF <= maxFQ)
    else $error("Target above maximum frequency");
endmodule : vhz_profile

// >>> testbench/vhz_modulator_model.sv
/*
  Behavioural three-phase modulator: integrates applied frequency into a phase.
  Assumes motorOut of the profile generator, sampled on mclk.
*/
`timescale 1ns/100ps
module vhz_modulator_model (
  input wire logic mclk,
  input wire logic reset,
  input wire vhz_pkg::vhzOut_t motorOut,
  output logic [31:0] phaseAngle
);
  import vhz_pkg::*;
  // Sink only, nothing returns to the generator
  always_ff @(posedge mclk) begin
    if (reset) begin
      phaseAngle <= 32'h0;
    end else if (motorOut.running) begin
      phaseAngle <= phaseAngle + {16'h0, motorOut.freq};
    end
  end
endmodule : vhz_modulator_model

// >>> testbench/volts_per_hertz_profile_bench.sv
/*
  Self-checking bench for the profile generator, APB master and monitor.
  Assumes the design package and a short tick count.
*/
`timescale 1ns/100ps
module volts_per_hertz_profile_bench;
  import vhz_pkg::*;
  localparam logic [15:0] RI [12] = '{IDX_CTRL, IDX_SPEED, IDX_SLEW, IDX_POLES, IDX_RATEDV,
    IDX_RATEDF, IDX_MINF, IDX_MAXF, IDX_INFLF, IDX_BOOSTV, IDX_STARTF, IDX_PAUSE};
  localparam logic [15:0] RV [12] = '{{14'h0, RST_CTRL}, RST_SPEED, RST_SLEW, RST_POLES,
    RST_RATEDV, RST_RATEDF, RST_MINF, RST_MAXF, RST_INFLF, RST_BOOSTV, RST_STARTF, RST_PAUSE};
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] prevF = '0;
  logic [15:0] cfg [256];
  vhzOut_t motorOut;
  int errors = 0, checkCount = 0, i, dstep;
  bit watch = 0;
  always #20 mclk = ~mclk;
  vhz_profile #(.TICK_CYCLES(4)) i_vhz_profile (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motorOut(motorOut));
  vhz_modulator_model i_vhz_modulator_model (.mclk(mclk), .reset(reset),
    .motorOut(motorOut), .phaseAngle());
  // ********************
  // Tasks and expectations
  // ********************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checkCount++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Answer taken at the rising edge, request released on that edge
    do begin
      @(posedge mclk);
      n++;
    end while (n < 20 && pready !== 1'b1);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    bit w;
    w = watch;
    watch = 0;
    apb(1'b1, idx, {16'h0, d});
    cfg[idx[7:0]] = d;
    repeat (3) @(negedge mclk);
    watch = w;
  endtask : wr
  function automatic int c(input logic [15:0] x);
    return cfg[x[7:0]];
  endfunction : c
  function automatic int line(input int f);
    return (f >= c(IDX_RATEDF)) ? c(IDX_RATEDV) : f * c(IDX_RATEDV) / c(IDX_RATEDF);
  endfunction : line
  function automatic int vexp(input int f);
    if (c(IDX_RATEDF) == 0) return 0;
    if (f >= c(IDX_RATEDF)) return c(IDX_RATEDV);
    if (f < c(IDX_INFLF)) return c(IDX_BOOSTV)
      + (line(c(IDX_INFLF)) - c(IDX_BOOSTV)) * f / c(IDX_INFLF);
    return line(f);
  endfunction : vexp
  function automatic int texp();
    int t;
    t = c(IDX_SPEED) * c(IDX_POLES) / int'(RPM_TO_DHZ_DIV);
    if (t < c(IDX_MINF)) t = c(IDX_MINF);
    if (t > c(IDX_MAXF)) t = c(IDX_MAXF);
    return t;
  endfunction : texp
  task automatic wait_f(input int t, input int lim);
    int n;
    n = 0;
    while (n < lim && motorOut.freq !== t[15:0]) begin
      @(negedge mclk);
      n++;
    end
    chk("freq", t, {16'h0, motorOut.freq});
  endtask : wait_f
  task printVerdict;
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : printVerdict
  // Running monitor of curve and slew
  always @(negedge mclk) begin
    if (watch && motorOut.running === 1'b1) begin
      dstep = (motorOut.freq > prevF) ? motorOut.freq - prevF : prevF - motorOut.freq;
      chk("volt", vexp(motorOut.freq), {16'h0, motorOut.volt});
      chk("slew step", 32'h1, {31'h0, dstep <= c(IDX_SLEW)});
    end
    prevF = motorOut.freq;
  end
  initial begin
    #(40 * 40000);
    errors++;
    printVerdict;
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    i = $urandom(90696);
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 12; i++) begin
      cfg[RI[i][7:0]] = RV[i];
      apb(1'b0, RI[i], 32'h0);
      chk("reset value", {16'h0, RV[i]}, rd);
    end
    apb(1'b0, 16'h8060, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, er});
    wr(IDX_STARTF, 16'h000a);
    wr(IDX_PAUSE, 16'h0002);
    wr(IDX_SLEW, 16'h0005);
    wr(IDX_SPEED, 16'h005a);
    apb(1'b1, IDX_CTRL, 32'h3);
    repeat (3) @(negedge mclk);
    chk("start freq", 32'ha, {16'h0, motorOut.freq});
    chk("running", 32'h1, {31'h0, motorOut.running});
    repeat (5) @(negedge mclk);
    chk("pause freq", 32'ha, {16'h0, motorOut.freq});
    wait_f(30, 60);
    watch = 1;
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status", {14'h0, 2'h2, 16'd30}, rd);
    wr(IDX_SPEED, 16'd5000);
    wait_f(texp(), 1200);
    chk("volt at max", {16'h0, RST_RATEDV}, {16'h0, motorOut.volt});
    wr(IDX_MINF, 16'd100);
    wr(IDX_SPEED, 16'd0);
    wait_f(100, 1200);
    wr(IDX_MINF, 16'd0);
    wr(IDX_BOOSTV, 16'd200);
    wr(IDX_INFLF, 16'd150);
    wr(IDX_SLEW, 16'd50);
    wait_f(0, 400);
    chk("boost volt", 32'd200, {16'h0, motorOut.volt});
    wr(IDX_SPEED, 16'd300);
    wait_f(100, 400);
    chk("low volt", 32'd833, {16'h0, motorOut.volt});
    wr(IDX_SPEED, 16'd600);
    wait_f(200, 400);
    chk("rated line volt", 32'd1533, {16'h0, motorOut.volt});
    apb(1'b0, IDX_VOLT, 32'h0);
    chk("volt register", 32'd1533, rd);
    for (i = 0; i < 6; i++) begin
      wr(IDX_SPEED, 16'($urandom_range(3000)));
      wait_f(texp(), 600);
    end
    apb(1'b1, IDX_CTRL, 32'h1);
    repeat (20) @(negedge mclk);
    chk("not induction", 32'h1, {31'h0, motorOut === '0});
    printVerdict;
  end
endmodule : volts_per_hertz_profile_bench
